/* rtl/baud_gen.v */
// Baud tick generator driven by divisor, prescaler and sample clock value
`timescale 1ns/1ns
module baud_gen (
    input wire clk, // UART input clock
    input wire sysRst, // Synchronous reset, high
    input wire ce, // Clock enable
    input wire [15:0] baudDivisor, // Divisor
    input wire [3:0] presM, // Prescaler M
    input wire [3:0] presN, // Prescaler N
    input wire presBit, // Prescale bit
    input wire [3:0] sampleClockValue, // Sample clock value S
    output reg baudTick_r // One pulse per bit time
);
    // Period = divisor * 2^(M+2p-1) * (16-S+N)
    wire [5:0] expo = {2'b00, presM} + {4'b0000, presBit, 1'b0};
    wire [5:0] samp = 6'h10 - {2'b00, sampleClockValue} + {2'b00, presN};
    wire [15:0] div = (baudDivisor == 16'h0000) ? 16'h0001 : baudDivisor;
    wire [63:0] prodB = {48'h0, div} * {58'h0, samp};
    wire [63:0] period = (expo == 6'h00) ? (prodB >> 1) : (prodB << (expo - 6'h01));
    reg [63:0] cnt_r;
    always @(posedge clk) begin
        if (sysRst) begin
            cnt_r <= 64'h0;
            baudTick_r <= 1'b0;
        end else if (ce) begin
            if (cnt_r + 64'h1 >= period) begin
                cnt_r <= 64'h0;
                baudTick_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 64'h1;
                baudTick_r <= 1'b0;
            end
        end
    end
endmodule // baud_gen

/* rtl/irq_flag.v */
// One sticky interrupt status flag
`timescale 1ns/1ns
module irq_flag (
    input wire clk, // System clock
    input wire sysRst, // Synchronous reset, high
    input wire ce, // Clock enable
    input wire setEv, // Source event
    input wire clrAll, // Clear request
    output reg flag_r // Sticky flag
);
    always @(posedge clk) begin
        if (sysRst) begin
            flag_r <= 1'b0;
        end else if (ce) begin
            if (setEv) begin
                flag_r <= 1'b1; // Set wins over clear
            end else if (clrAll) begin
                flag_r <= 1'b0;
            end
        end
    end
endmodule // irq_flag

/* rtl/uart_ext_ctrl_irq_status_regs.v */
// Extended control and interrupt status registers of the UART bridge
`timescale 1ns/1ns
`include "uart_ext_defs.vh"
// How it works
// - Control register reachable only with line control 0xbf and special bit 2; resets 0x06
// - Interrupt status register behind same gate; resets to zero
// - Control bits 7:4 hold S feeding the baud divider formula
// - Control bit 3 enables in-band Xon transmission
// - Control bit 2 enables transmitter-empty interrupt
// - Status bit 3 shows receive timeout; control bit 1 enables timeout
// - Control bit 0 enables idle insertion between characters
// - Status bit 7 shows CTS/RTS change interrupt
// - Status bit 6 shows Xoff or special character interrupt
// - Status bit 5 shows modem status interrupt
// - Status bit 4 shows transmit holding interrupt
// - Status bit 2 shows receive holding data interrupt
// - Status bit 1 shows receive line error interrupt
// - Writing one to status bit 0 clears all flags except those whose event arrives in the same cycle; bit self-clears
// - Special bit 2 gates prescaler, control and status registers; special register itself needs only line control 0xbf
// - Prescaler holds M in 7:4 and N in 3:0 for baud
module uart_ext_ctrl_irq_status_regs #(
    parameter DIV_W = 16 // Divisor width
) (
    input wire clk, // System clock, 100 MHz
    input wire sys_rst, // Synchronous reset, high
    input wire ce, // Clock enable
    input wire [3:0] regAddr, // Register offset
    input wire regWr, // Write strobe
    input wire regRd, // Read strobe
    input wire [7:0] regWdata, // Write data
    input wire [DIV_W-1:0] baudDivisor, // Divisor from divisor latch
    input wire evCtsRts, // CTS/RTS change event
    input wire evXoff, // Xoff or special char event
    input wire evModem, // Modem status event
    input wire evTxHold, // Transmit holding event
    input wire evRxTimeout, // Receiver timeout event
    input wire evRxData, // Receive data event
    input wire evLineErr, // Receive line error event
    input wire txEmpty, // Transmitter empty level
    output reg [7:0] regRdata_r, // Read data
    output reg regRvalid_r, // Read data valid pulse
    output reg baudTick_r, // Baud tick
    output reg xonTxEn_r, // In-band Xon enable
    output reg txEmptyIrq_r, // Transmitter empty interrupt
    output reg rxTimeoutEn_r, // Receive timeout enable
    output reg idleInsertEn_r, // Idle insertion enable
    output reg irqAny_r // Any status flag set
);
    reg [7:0] lineControl_r;
    reg [7:0] specialFunction_r;
    reg [7:0] modemControl_r;
    reg [7:0] clockPrescaler_r;
    reg [7:0] txrxControl_r;
    reg clrPulse_r;
    wire [6:0] flags;
    wire [6:0] events;
    wire baudTick;
    wire extOpen = (lineControl_r == `LINECTL_EXT_KEY) && specialFunction_r[`SPECIAL_EXT_BIT];
    wire clrReq = regWr && extOpen && (regAddr == `OFS_IRQSTAT) && regWdata[`IRQSTAT_CLR_BIT];
    wire rtoEv = evRxTimeout && txrxControl_r[`TXRXCTL_RTO_BIT];

    // Flag order: bit7..bit1 of status register
    assign events = {evCtsRts, evXoff, evModem, evTxHold, rtoEv, evRxData, evLineErr};

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1) begin : gFlag
            irq_flag uFlag (
                .clk(clk),
                .sysRst(sys_rst),
                .ce(ce),
                .setEv(events[gi]),
                .clrAll(clrReq),
                .flag_r(flags[gi])
            );
        end
    endgenerate

    baud_gen uBaud (
        .clk(clk),
        .sysRst(sys_rst),
        .ce(ce),
        .baudDivisor(baudDivisor[15:0]),
        .presM(clockPrescaler_r[`PRESCALE_M_HI:`PRESCALE_M_LO]),
        .presN(clockPrescaler_r[`PRESCALE_N_HI:`PRESCALE_N_LO]),
        .presBit(modemControl_r[`MODEMCTL_PRESC_BIT]),
        .sampleClockValue(txrxControl_r[`TXRXCTL_SCV_HI:`TXRXCTL_SCV_LO]),
        .baudTick_r(baudTick)
    );

    // Register writes
    always @(posedge clk) begin
        if (sys_rst) begin
            lineControl_r <= `RST_LINECTL;
            specialFunction_r <= `RST_SPECIAL;
            modemControl_r <= `RST_MODEMCTL;
            clockPrescaler_r <= `RST_PRESCALE;
            txrxControl_r <= `RST_TXRXCTL;
            clrPulse_r <= 1'b0;
        end else if (ce) begin
            clrPulse_r <= clrReq;
            if (regWr) begin
                if (regAddr == `OFS_LINECTL) begin
                    lineControl_r <= regWdata;
                end else if (regAddr == `OFS_MODEMCTL) begin
                    modemControl_r <= regWdata;
                end else if (regAddr == `OFS_SPECIAL && lineControl_r == `LINECTL_EXT_KEY) begin
                    specialFunction_r <= regWdata;
                end else if (regAddr == `OFS_PRESCALE && extOpen) begin
                    clockPrescaler_r <= regWdata;
                end else if (regAddr == `OFS_TXRXCTL && extOpen) begin
                    txrxControl_r <= regWdata;
                end
            end
        end
    end

    // Read path and outputs
    always @(posedge clk) begin
        if (sys_rst) begin
            regRdata_r <= 8'h00;
            regRvalid_r <= 1'b0;
            baudTick_r <= 1'b0;
            xonTxEn_r <= 1'b0;
            txEmptyIrq_r <= 1'b0;
            rxTimeoutEn_r <= 1'b0;
            idleInsertEn_r <= 1'b0;
            irqAny_r <= 1'b0;
        end else if (ce) begin
            regRvalid_r <= regRd;
            if (regRd) begin
                if (regAddr == `OFS_LINECTL) begin
                    regRdata_r <= lineControl_r;
                end else if (regAddr == `OFS_MODEMCTL) begin
                    regRdata_r <= modemControl_r;
                end else if (regAddr == `OFS_SPECIAL && lineControl_r == `LINECTL_EXT_KEY) begin
                    regRdata_r <= specialFunction_r;
                end else if (regAddr == `OFS_PRESCALE && extOpen) begin
                    regRdata_r <= clockPrescaler_r;
                end else if (regAddr == `OFS_TXRXCTL && extOpen) begin
                    regRdata_r <= txrxControl_r;
                end else if (regAddr == `OFS_IRQSTAT && extOpen) begin
                    // Clear bit always reads zero
                    regRdata_r <= {flags, 1'b0};
                end else begin
                    regRdata_r <= 8'h00;
                end
            end
            baudTick_r <= baudTick;
            xonTxEn_r <= txrxControl_r[`TXRXCTL_XON_BIT];
            txEmptyIrq_r <= txrxControl_r[`TXRXCTL_TXE_BIT] && txEmpty;
            rxTimeoutEn_r <= txrxControl_r[`TXRXCTL_RTO_BIT];
            idleInsertEn_r <= txrxControl_r[`TXRXCTL_IDLE_BIT];
            irqAny_r <= |flags;
        end
    end
endmodule // uart_ext_ctrl_irq_status_regs

/* rtl/uart_ext_defs.vh */
// Offsets, field positions, reset values and access keys of the extended UART registers
`ifndef UART_EXT_DEFS_VH
`define UART_EXT_DEFS_VH
`define OFS_SPECIAL 4'h7
`define OFS_PRESCALE 4'h1
`define OFS_LINECTL 4'h3
`define OFS_MODEMCTL 4'h4
`define OFS_TXRXCTL 4'h9
`define OFS_IRQSTAT 4'hf
`define LINECTL_EXT_KEY 8'hbf
`define SPECIAL_EXT_BIT 2
`define RST_TXRXCTL 8'h06
`define RST_IRQSTAT 8'h00
`define RST_PRESCALE 8'h00
`define RST_LINECTL 8'h00
`define RST_SPECIAL 8'h00
`define RST_MODEMCTL 8'h00
`define TXRXCTL_SCV_HI 7
`define TXRXCTL_SCV_LO 4
`define TXRXCTL_XON_BIT 3
`define TXRXCTL_TXE_BIT 2
`define TXRXCTL_RTO_BIT 1
`define TXRXCTL_IDLE_BIT 0
`define PRESCALE_M_HI 7
`define PRESCALE_M_LO 4
`define PRESCALE_N_HI 3
`define PRESCALE_N_LO 0
`define MODEMCTL_PRESC_BIT 7
`define IRQSTAT_CTSRTS_BIT 7
`define IRQSTAT_XOFF_BIT 6
`define IRQSTAT_MODEM_BIT 5
`define IRQSTAT_TXHOLD_BIT 4
`define IRQSTAT_RTO_BIT 3
`define IRQSTAT_RXDATA_BIT 2
`define IRQSTAT_LERR_BIT 1
`define IRQSTAT_CLR_BIT 0
`endif

/* testbench/host_model.sv */
// Host side register access model
`timescale 1ns/1ns
module host_model (
    input wire clk, // Clock
    input wire [7:0] regRdata_r, // Read data
    output reg [3:0] regAddr = 4'h0, // Offset
    output reg regWr = 1'b0, // Write strobe
    output reg regRd = 1'b0, // Read strobe
    output reg [7:0] regWdata = 8'h00 // Write data
);
    task wr(input [3:0] a, input [7:0] v);
        begin
            @(posedge clk);
            regAddr <= a;
            regWdata <= v;
            regWr <= 1'b1;
            @(posedge clk);
            regWr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, output [7:0] v);
        begin
            @(posedge clk);
            regAddr <= a;
            regRd <= 1'b1;
            @(posedge clk);
            regRd <= 1'b0;
            #1;
            v = regRdata_r;
        end
    endtask
endmodule // host_model

/* testbench/uart_ext_ctrl_irq_status_regs_tb.sv */
// Register level test of the extended UART control and status block
`timescale 1ns/1ns
module uart_ext_ctrl_irq_status_regs_tb;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg [6:0] ev = 7'h00;
    reg txEmpty = 1'b0;
    wire [3:0] regAddr;
    wire regWr, regRd, regRvalid_r, baudTick_r, xonTxEn_r, txEmptyIrq_r, rxTimeoutEn_r, idleInsertEn_r, irqAny_r;
    wire [7:0] regWdata, regRdata_r;
    integer n_mismatch = 0;
    integer checked = 0;
    integer cyc = 0;
    integer i;
    time t0;
    reg [7:0] d, acc;
    always #5 clk = ~clk;
    uart_ext_ctrl_irq_status_regs dut_u (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .regAddr(regAddr),
        .regWr(regWr), .regRd(regRd), .regWdata(regWdata), .baudDivisor(16'h0001), .evCtsRts(ev[6]),
        .evXoff(ev[5]), .evModem(ev[4]), .evTxHold(ev[3]), .evRxTimeout(ev[2]), .evRxData(ev[1]),
        .evLineErr(ev[0]),
        .txEmpty(txEmpty), .regRdata_r(regRdata_r), .regRvalid_r(regRvalid_r), .baudTick_r(baudTick_r),
        .xonTxEn_r(xonTxEn_r), .txEmptyIrq_r(txEmptyIrq_r), .rxTimeoutEn_r(rxTimeoutEn_r),
        .idleInsertEn_r(idleInsertEn_r), .irqAny_r(irqAny_r));
    host_model host_u (.clk(clk), .regRdata_r(regRdata_r), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
        .regWdata(regWdata));
    task finish_test;
        begin
            $display("mismatches %0d checks %0d", n_mismatch, checked);
            if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    task cmp(input [7:0] got, input [7:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task rdc(input [3:0] a, input [7:0] exp);
        begin
            host_u.rd(a, d);
            cmp(d, exp);
        end
    endtask
    task pulse(input [6:0] v);
        begin
            @(posedge clk);
            ev <= v;
            @(posedge clk);
            ev <= 7'h00;
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_mismatch = n_mismatch + 1;
            finish_test;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rdc(4'h9, 8'h00);
        host_u.wr(4'h9, 8'hff);
        host_u.wr(4'h3, 8'hbf);
        rdc(4'h9, 8'h00);
        host_u.wr(4'h7, 8'h04);
        rdc(4'h9, 8'h06);
        rdc(4'hf, 8'h00);
        host_u.wr(4'h9, 8'h0b);
        repeat (2) @(posedge clk);
        #1;
        cmp({4'h0, xonTxEn_r, txEmptyIrq_r, rxTimeoutEn_r, idleInsertEn_r}, 8'h0b);
        acc = 8'h00;
        for (i = 0; i < 7; i = i + 1) begin
            pulse(7'h01 << i);
            acc = acc | (8'h02 << i);
            rdc(4'hf, acc);
        end
        host_u.wr(4'hf, 8'h01);
        rdc(4'hf, 8'h00);
        host_u.wr(4'h9, 8'h04);
        txEmpty <= 1'b1;
        pulse(7'h04);
        rdc(4'hf, 8'h00);
        cmp({7'h00, txEmptyIrq_r}, 8'h01);
        host_u.wr(4'h1, 8'h13);
        host_u.wr(4'h9, 8'hf0);
        @(posedge baudTick_r);
        @(posedge baudTick_r);
        t0 = $time;
        @(posedge baudTick_r);
        cmp(8'(($time - t0) / 10), 8'h04);
        host_u.wr(4'h7, 8'h00);
        rdc(4'h9, 8'h00);
        finish_test;
    end
endmodule // uart_ext_ctrl_irq_status_regs_tb

/* testbench/uart_ext_regs_monitor.sv */
// Port checker for the extended UART register block
`timescale 1ns/1ns
module uart_ext_regs_monitor (
    input wire clk, // Clock
    input wire sys_rst, // Reset
    input wire ce, // Enable
    input wire regRd, // Read strobe
    input wire evCtsRts, // Event
    input wire evXoff, // Event
    input wire evModem, // Event
    input wire evTxHold, // Event
    input wire evRxData, // Event
    input wire evLineErr, // Event
    input wire txEmpty, // Level
    input wire regRvalid_r, // Read valid
    input wire txEmptyIrq_r, // Interrupt
    input wire irqAny_r // Any flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_read_answer: assert property (ce && regRd |=> regRvalid_r) else $error("read not answered");
    chk_read_cause: assert property (regRvalid_r && $past(ce) |-> $past(regRd)) else $error("stray read valid");
    chk_cts_flag: assert property (ce && evCtsRts ##1 ce |=> irqAny_r) else $error("cts flag lost");
    chk_xoff_flag: assert property (ce && evXoff ##1 ce |=> irqAny_r) else $error("xoff flag lost");
    chk_modem_flag: assert property (ce && evModem ##1 ce |=> irqAny_r) else $error("modem flag lost");
    chk_txhold_flag: assert property (ce && evTxHold ##1 ce |=> irqAny_r) else $error("tx hold flag lost");
    chk_rxdata_flag: assert property (ce && evRxData ##1 ce |=> irqAny_r) else $error("rx data flag lost");
    chk_lerr_flag: assert property (ce && evLineErr ##1 ce |=> irqAny_r) else $error("lerr flag lost");
    chk_txe_cause: assert property (txEmptyIrq_r && $past(ce) |-> $past(txEmpty)) else $error("txe irq");
    cover property (irqAny_r);
    cover property (txEmptyIrq_r);
    cover property (regRvalid_r);
endmodule // uart_ext_regs_monitor
bind uart_ext_ctrl_irq_status_regs uart_ext_regs_monitor mon_u (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .regRd(regRd), .evCtsRts(evCtsRts), .evXoff(evXoff), .evModem(evModem), .evTxHold(evTxHold),
    .evRxData(evRxData),
    .evLineErr(evLineErr), .txEmpty(txEmpty), .regRvalid_r(regRvalid_r), .txEmptyIrq_r(txEmptyIrq_r),
    .irqAny_r(irqAny_r));
